// *** rtl/sarc_top.sv ***
`default_nettype none

module sarc_top
    import sarc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    // Start sources and chip power state
    input wire logic timer3_ovf_in,
    input wire logic timer2_ovf_in,
    input wire logic external_convert_start_in,
    input wire logic standby_in,
    // Analog front end
    input wire logic comp_in,
    output sarc_analog_t analog_out,
    output logic [RES_BITS-1:0] dac_code_out,
    // Status
    output logic conversion_done_out
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b10
    } sarc_state_t;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic en_reg, en_next;
    logic tm_reg, tm_next;
    logic done_reg, done_next;
    sarc_start_t cm_reg, cm_next;
    logic lj_reg, lj_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [3:0] chsel_reg, chsel_next;
    logic [3:0] pair_reg, pair_next;
    logic [RES_BITS-1:0] result_reg, result_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    sarc_state_t state_reg, state_next;
    logic [1:0] trk_reg, trk_next;
    logic [GAP_W-1:0] gap_reg, gap_next;
    logic ext_prev_reg;
    sarc_analog_t analog_reg, analog_next;

    logic ctl_wr, busy, trig, accept, ext_rise, tick, sar_start, sar_done;
    logic [RES_BITS-1:0] sar_result;
    logic [7:0] res_hi, res_lo;
    logic [1:0] pair_idx;

    assign busy = (state_reg != ST_IDLE);
    assign ctl_wr = wr_in && (addr_in == OFF_CTRL);
    assign ext_rise = external_convert_start_in && !ext_prev_reg;

    // ------------------------------------------------------------
    // Control register and start selection
    // ------------------------------------------------------------
    always_comb begin
        en_next = en_reg;
        tm_next = tm_reg;
        cm_next = cm_reg;
        lj_next = lj_reg;
        if (ctl_wr) begin
            en_next = wdata_in[CTRL_EN_BIT];
            tm_next = wdata_in[CTRL_TM_BIT];
            cm_next = sarc_start_t'(wdata_in[CTRL_CM_LSB +: 2]);
            lj_next = wdata_in[CTRL_LJ_BIT];
        end
        // A write starts with the fields it carries.
        case (cm_next)
            START_SW: trig = ctl_wr && wdata_in[CTRL_BUSY_BIT];
            START_T3: trig = timer3_ovf_in;
            START_EXT: trig = ext_rise;
            default: trig = timer2_ovf_in;
        endcase
        accept = trig && en_next && !busy && (gap_reg == '0);
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        trk_next = trk_reg;
        sar_start = 1'b0;
        gap_next = (gap_reg != '0) ? gap_reg - 1'b1 : gap_reg;
        if (!en_next) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        gap_next = GAP_W'(MIN_CONV_CYC - 1);
                        trk_next = 2'h0;
                        if (tm_next && cm_next != START_EXT) begin
                            state_next = ST_TRACK;
                        end else begin
                            state_next = ST_CONV;
                            sar_start = 1'b1;
                        end
                    end
                end
                ST_TRACK: begin
                    if (tick) begin
                        trk_next = trk_reg + 2'h1;
                        if (trk_reg == TRACK_TICKS - 2'h1) begin
                            state_next = ST_CONV;
                            sar_start = 1'b1;
                        end
                    end
                end
                ST_CONV: begin
                    if (sar_done) begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Other registers, done flag and result
    // ------------------------------------------------------------
    always_comb begin
        cfg_next = cfg_reg;
        chsel_next = chsel_reg;
        pair_next = pair_reg;
        done_next = done_reg;
        result_next = result_reg;
        if (wr_in && addr_in == OFF_CFG) begin
            cfg_next = wdata_in;
        end
        if (wr_in && addr_in == OFF_CHSEL) begin
            chsel_next = wdata_in[3:0];
        end
        if (wr_in && addr_in == OFF_PAIR) begin
            pair_next = wdata_in[3:0];
        end
        if (ctl_wr) begin
            done_next = wdata_in[CTRL_DONE_BIT];
        end
        if (state_reg == ST_CONV && sar_done && en_next) begin
            done_next = 1'b1;
            result_next = sar_result;
        end
    end

    // Result bytes are justified as they are read.
    always_comb begin
        if (lj_reg) begin
            res_hi = result_reg[11:4];
            res_lo = {result_reg[3:0], 4'h0};
        end else begin
            res_hi = {4'h0, result_reg[11:8]};
            res_lo = result_reg[7:0];
        end
        rdata_next = '0;
        if (!rd_in) begin
            rdata_next = '0;
        end else if (addr_in == OFF_CTRL) begin
            rdata_next = {en_reg, tm_reg, done_reg, busy, cm_reg, 1'b0,
                lj_reg};
        end else if (addr_in == OFF_CFG) begin
            rdata_next = cfg_reg;
        end else if (addr_in == OFF_CHSEL) begin
            rdata_next = {4'h0, chsel_reg};
        end else if (addr_in == OFF_PAIR) begin
            rdata_next = {4'h0, pair_reg};
        end else if (addr_in == OFF_RES_HI) begin
            rdata_next = res_hi;
        end else if (addr_in == OFF_RES_LO) begin
            rdata_next = res_lo;
        end
    end

    // ------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------
    assign pair_idx = chsel_reg[2:1];

    always_comb begin
        analog_next.enable = en_reg;
        analog_next.gain = sarc_gain_decode(cfg_reg[CFG_GAIN_LSB +: 3]);
        analog_next.temp_sel = chsel_reg[3];
        analog_next.diff = !chsel_reg[3] && pair_reg[pair_idx];
        analog_next.ain_pos = analog_next.diff ? {pair_idx, 1'b0}
            : chsel_reg[2:0];
        if (!en_reg || standby_in) begin
            analog_next.track = 1'b0;
        end else if (!tm_reg) begin
            analog_next.track = !busy;
        end else if (cm_reg == START_EXT) begin
            analog_next.track = !busy && !external_convert_start_in;
        end else begin
            analog_next.track = (state_reg == ST_TRACK);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_reg <= RST_CTRL[CTRL_EN_BIT];
            tm_reg <= RST_CTRL[CTRL_TM_BIT];
            done_reg <= RST_CTRL[CTRL_DONE_BIT];
            cm_reg <= sarc_start_t'(RST_CTRL[CTRL_CM_LSB +: 2]);
            lj_reg <= RST_CTRL[CTRL_LJ_BIT];
            cfg_reg <= RST_CFG;
            chsel_reg <= RST_CHSEL;
            pair_reg <= RST_PAIR;
            result_reg <= '0;
            rdata_reg <= '0;
            state_reg <= ST_IDLE;
            trk_reg <= 2'h0;
            gap_reg <= '0;
            ext_prev_reg <= 1'b0;
            analog_reg <= '0;
        end else begin
            en_reg <= en_next;
            tm_reg <= tm_next;
            done_reg <= done_next;
            cm_reg <= cm_next;
            lj_reg <= lj_next;
            cfg_reg <= cfg_next;
            chsel_reg <= chsel_next;
            pair_reg <= pair_next;
            result_reg <= result_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            trk_reg <= trk_next;
            gap_reg <= gap_next;
            ext_prev_reg <= external_convert_start_in;
            analog_reg <= analog_next;
        end
    end

    sarc_clkdiv #(.W(DIV_W)) u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(busy),
        .div_in(cfg_reg[CFG_DIV_LSB +: DIV_W]),
        .tick_out(tick)
    );

    sarc_sar #(.BITS(RES_BITS)) u_sar (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(sar_start),
        .abort_in(!en_next),
        .tick_in(tick),
        .comp_in(comp_in),
        .dac_code_out(dac_code_out),
        .result_out(sar_result),
        .done_out(sar_done)
    );

    assign rdata_out = rdata_reg;
    assign analog_out = analog_reg;
    assign conversion_done_out = done_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_off_idle;
        @(posedge clk_in) disable iff (rst_in) !en_reg |-> !busy;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("converter busy while disabled");

    property p_temp;
        @(posedge clk_in) disable iff (rst_in)
        chsel_reg[3] |=> analog_out.temp_sel && !analog_out.diff;
    endproperty
    a_temp: assert property (p_temp)
        else $error("temperature channel not selected");

    property p_pair;
        @(posedge clk_in) disable iff (rst_in)
        (!chsel_reg[3] && pair_reg[chsel_reg[2:1]]) |=>
            analog_out.diff && !analog_out.ain_pos[0];
    endproperty
    a_pair: assert property (p_pair)
        else $error("differential pair not applied");

    property p_gain;
        @(posedge clk_in) disable iff (rst_in)
        (cfg_reg[2:1] == 2'b11) |=> analog_out.gain == GAIN_HALF;
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain code 11x not half");

    property p_busy_end;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_CONV && sar_done && en_next) |=> !busy && done_reg;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("done flag not set as busy fell");

    property p_track3;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_IDLE && state_next == ST_TRACK) |=>
            (state_reg == ST_TRACK)[*3];
    endproperty
    a_track3: assert property (p_track3)
        else $error("tracking phase shorter than three clocks");

    property p_rate;
        @(posedge clk_in) disable iff (rst_in)
        accept |=> !accept [*8];
    endproperty
    a_rate: assert property (p_rate)
        else $error("conversions started too close together");

    property p_ignore;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_CONV && trig && !sar_done && en_next) |=>
            state_reg == ST_CONV;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("trigger disturbed running conversion");

    property p_standby;
        @(posedge clk_in) disable iff (rst_in)
        standby_in |=> !analog_out.track;
    endproperty
    a_standby: assert property (p_standby)
        else $error("tracking during standby");

    property p_cont;
        @(posedge clk_in) disable iff (rst_in)
        (en_reg && !tm_reg && !standby_in && !busy) |=> analog_out.track;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous tracking missing");

    c_done: cover property (@(posedge clk_in) $fell(busy) && done_reg);
    c_track: cover property (@(posedge clk_in) state_reg == ST_TRACK);
    c_ext: cover property (@(posedge clk_in) accept && ext_rise);
    c_drop: cover property (@(posedge clk_in) busy && trig);

endmodule

`default_nettype wire

// *** rtl/sarc_pkg.sv ***
// Contract
// - Converter runs only while enable bit set
// - Nine channels: eight inputs plus temperature
// - Pairs single-ended or differential, reset single-ended
// - Gain from config field, unity at reset
// - Conversion clock divided from system clock
// - Throughput never above one hundred ksps
// - One start source chosen by start field
// - Busy reads one throughout each conversion
// - Busy falling sets done flag bit five
// - Twelve-bit result left or right justified
// - Default mode tracks whenever not converting
// - Low-power mode tracks three SAR clocks first
// - External start: convert rising; low-power mode tracks while low
// - No tracking during chip standby or sleep
// - Start field: software, timer3, pin, timer2
// - SAR clock is system clock over field+1
// - Gain codes map 1,2,4,8,16,16,0.5,0.5
`default_nettype none

package sarc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_CFG = 3'h1;
    localparam logic [2:0] OFF_CHSEL = 3'h2;
    localparam logic [2:0] OFF_PAIR = 3'h3;
    localparam logic [2:0] OFF_RES_HI = 3'h4;
    localparam logic [2:0] OFF_RES_LO = 3'h5;

    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_TM_BIT = 6;
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_CM_LSB = 2;
    localparam int CTRL_LJ_BIT = 0;
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_GAIN_LSB = 0;

    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CFG = 8'hf8;
    localparam logic [3:0] RST_CHSEL = 4'h0;
    localparam logic [3:0] RST_PAIR = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RES_BITS = 12;
    localparam int DIV_W = 5;
    localparam logic [1:0] TRACK_TICKS = 2'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MIN_CONV_PERIOD_NS = 10000;
    localparam int MIN_CONV_CYC =
        (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W = $clog2(MIN_CONV_CYC);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        START_SW = 2'b00,
        START_T3 = 2'b01,
        START_EXT = 2'b10,
        START_T2 = 2'b11
    } sarc_start_t;

    typedef enum logic [2:0] {
        GAIN_1 = 3'b000,
        GAIN_2 = 3'b001,
        GAIN_4 = 3'b010,
        GAIN_8 = 3'b011,
        GAIN_16 = 3'b100,
        GAIN_HALF = 3'b101
    } sarc_gain_t;

    typedef struct packed {
        logic enable;
        logic track;
        sarc_gain_t gain;
        logic temp_sel;
        logic diff;
        logic [2:0] ain_pos;
    } sarc_analog_t;

    // Field codes 10x and 11x each collapse onto a single gain.
    function automatic sarc_gain_t sarc_gain_decode(input logic [2:0] f);
        sarc_gain_t g;
        g = GAIN_1;
        if (f[2]) begin
            g = f[1] ? GAIN_HALF : GAIN_16;
        end else begin
            g = sarc_gain_t'(f);
        end
        return g;
    endfunction

endpackage

`default_nettype wire

// *** rtl/sarc_clkdiv.sv ***
`default_nettype none

module sarc_clkdiv
    import sarc_pkg::*;
#(
    parameter int W = DIV_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic run_in,
    input wire logic [W-1:0] div_in,
    // Tick
    output logic tick_out
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // Counter restarts with every run so the first tick is a full period.
    always_comb begin
        if (!run_in || cnt_reg == div_in) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick_out = run_in && (cnt_reg == div_in);

endmodule

`default_nettype wire

// *** rtl/sarc_sar.sv ***
`default_nettype none

module sarc_sar
    import sarc_pkg::*;
#(
    parameter int BITS = RES_BITS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic tick_in,
    input wire logic comp_in,
    // Results
    output logic [BITS-1:0] dac_code_out,
    output logic [BITS-1:0] result_out,
    output logic done_out
);

    logic [BITS-1:0] code_reg, code_next;
    logic [BITS-1:0] mask_reg, mask_next;
    logic [BITS-1:0] res_reg, res_next;
    logic active_reg, active_next;
    logic done_reg, done_next;
    logic [BITS-1:0] kept;

    // One bit is decided per SAR clock, most significant first.
    always_comb begin
        code_next = code_reg;
        mask_next = mask_reg;
        res_next = res_reg;
        active_next = active_reg;
        done_next = 1'b0;
        kept = comp_in ? code_reg : (code_reg & ~mask_reg);
        if (abort_in) begin
            active_next = 1'b0;
            code_next = '0;
        end else if (start_in) begin
            mask_next = {1'b1, {(BITS-1){1'b0}}};
            code_next = {1'b1, {(BITS-1){1'b0}}};
            active_next = 1'b1;
        end else if (active_reg && tick_in) begin
            mask_next = mask_reg >> 1;
            code_next = kept | (mask_reg >> 1);
            if (mask_reg[0]) begin
                active_next = 1'b0;
                res_next = kept;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            code_reg <= '0;
            mask_reg <= '0;
            res_reg <= '0;
            active_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            code_reg <= code_next;
            mask_reg <= mask_next;
            res_reg <= res_next;
            active_reg <= active_next;
            done_reg <= done_next;
        end
    end

    assign dac_code_out = code_reg;
    assign result_out = res_reg;
    assign done_out = done_reg;

endmodule

`default_nettype wire

// *** tb/sarc_src_model.sv ***
`default_nettype none

module sarc_src_model (
    // Clock
    input wire logic clk_in,
    // Analog side
    input wire logic [11:0] vin_in,
    input wire logic [11:0] dac_code_in,
    output logic comp_out,
    // Start sources
    output logic timer3_ovf_out,
    output logic timer2_ovf_out,
    output logic external_convert_start_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // An ideal comparator keeps the trial bit while the input is not below.
    assign comp_out = (vin_in >= dac_code_in);

    initial begin
        timer3_ovf_out = 1'b0;
        timer2_ovf_out = 1'b0;
        external_convert_start_out = 1'b0;
    end

    // Pulses one hardware source for one cycle; code 0 is software only.
    task automatic fire(input logic [1:0] src);
        @(posedge clk_in);
        case (src)
            2'h1: timer3_ovf_out <= 1'b1;
            2'h2: external_convert_start_out <= 1'b1;
            2'h3: timer2_ovf_out <= 1'b1;
            default: ;
        endcase
        @(posedge clk_in);
        timer3_ovf_out <= 1'b0;
        timer2_ovf_out <= 1'b0;
        external_convert_start_out <= 1'b0;
    endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none

module tb_top
    import sarc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] addr_in;
    logic [DATA_W-1:0] wdata_in, rdata_out;
    logic wr_in, rd_in, standby_in, comp, done_out, t3, t2, pin;
    logic [11:0] vin, dac;
    sarc_analog_t analog_out;
    int errors, cmp_count, div, cyc;
    logic [3:0] p, c;

    always #5 clk_in = ~clk_in;

    sarc_top dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .timer3_ovf_in(t3), .timer2_ovf_in(t2),
        .external_convert_start_in(pin), .standby_in(standby_in),
        .comp_in(comp), .analog_out(analog_out), .dac_code_out(dac),
        .conversion_done_out(done_out));

    sarc_src_model src_m (.clk_in(clk_in), .vin_in(vin),
        .dac_code_in(dac), .comp_out(comp), .timer3_ovf_out(t3),
        .timer2_ovf_out(t2), .external_convert_start_out(pin));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                       input string what);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(what, {8'h0, e}, {8'h0, rdata_out});
    endtask

    function automatic logic [7:0] cv(input logic tm, b,
                                      input logic [1:0] s, input logic lj);
        return {1'b1, tm, 1'b0, b, s, 1'b0, lj};
    endfunction

    function automatic logic [2:0] exp_gain(input logic [2:0] f);
        if (f[2]) begin
            return f[1] ? 3'h5 : 3'h4;
        end
        return f;
    endfunction

    // ------------------------------------------------------------
    // One conversion from the chosen source, with its checks
    // ------------------------------------------------------------
    task automatic convert(input logic [1:0] src, input logic tm, lj);
        logic [11:0] v;
        int n, e;
        v = 12'($urandom);
        repeat (1000) @(posedge clk_in);
        vin <= v;
        wr(OFF_CTRL, cv(tm, 1'b0, src, lj));
        for (int k = 0; k < 4; k++) begin
            if (k[1:0] == src) continue;
            if (k == 0) wr(OFF_CTRL, cv(tm, 1'b1, src, lj));
            else src_m.fire(k[1:0]);
        end
        rdc(OFF_CTRL, cv(tm, 1'b0, src, lj), "busy other source");
        chk("track idle", {15'h0, !tm || src == 2'h2},
            {15'h0, analog_out.track});
        if (src == 2'h0) wr(OFF_CTRL, cv(tm, 1'b1, src, lj));
        else src_m.fire(src);
        n = 2;
        rdc(OFF_CTRL, cv(tm, 1'b1, src, lj), "busy running");
        if (src == 2'h0) begin
            wr(OFF_CTRL, cv(tm, 1'b1, src, lj));
            n = 4;
        end
        while (done_out !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk("done wait", 16'h1, 16'(n < 400));
        rdc(OFF_CTRL, cv(tm, 1'b0, src, lj) | 8'h20, "done set");
        if (src == 2'h0) begin
            e = (12 + 3 * tm) * (div + 1) + 1;
            chk("conversion length", 16'h1,
                16'(n >= e - div - 3 && n <= e + div + 3));
            wr(OFF_CTRL, cv(tm, 1'b1, src, lj) | 8'h20);
            rdc(OFF_CTRL, cv(tm, 1'b0, src, lj) | 8'h20, "early start");
        end
        rdc(OFF_RES_HI, lj ? v[11:4] : {4'h0, v[11:8]}, "result high");
        rdc(OFF_RES_LO, lj ? {v[3:0], 4'h0} : v[7:0], "result low");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        cmp_count = 0;
        div = 31;
        addr_in = '0;
        wdata_in = '0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        standby_in = 1'b0;
        vin = '0;
        void'($urandom(32'hf9f8));
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rdc(OFF_CTRL, RST_CTRL, "control reset");
        rdc(OFF_CFG, RST_CFG, "config reset");
        rdc(OFF_CHSEL, 8'h00, "channel reset");
        rdc(OFF_PAIR, 8'h00, "pair reset");
        chk("analog reset", 16'h0, {6'h0, analog_out});
        wr(3'h7, 8'hff);
        rdc(3'h7, 8'h00, "unmapped");
        wr(OFF_CTRL, 8'h80);
        @(posedge clk_in);
        #1;
        chk("enable on", 16'h1, {15'h0, analog_out.enable});
        chk("gain reset", 16'h0, {13'h0, analog_out.gain});
        chk("track continuous", 16'h1, {15'h0, analog_out.track});
        @(posedge clk_in);
        standby_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("track standby", 16'h0, {15'h0, analog_out.track});
        standby_in <= 1'b0;
        for (int g = 0; g < 8; g++) begin
            wr(OFF_CFG, 8'(g));
            @(posedge clk_in);
            #1;
            chk("gain", {13'h0, exp_gain(3'(g))},
                {13'h0, analog_out.gain});
        end
        div = 0;
        for (int i = 0; i < 16; i++) begin
            p = 4'($urandom);
            c = (i < 9) ? 4'(i) : 4'($urandom % 9);
            wr(OFF_PAIR, {4'h0, p});
            wr(OFF_CHSEL, {4'h0, c});
            @(posedge clk_in);
            #1;
            chk("temp select", {15'h0, c[3]},
                {15'h0, analog_out.temp_sel});
            if (!c[3]) begin
                chk("diff", {15'h0, p[c[2:1]]}, {15'h0, analog_out.diff});
                chk("input", {13'h0, p[c[2:1]] ? {c[2:1], 1'b0} : c[2:0]},
                    {13'h0, analog_out.ain_pos});
            end
        end
        for (int i = 0; i < 4; i++) convert(2'(i), 1'b0, i[0]);
        for (int i = 1; i < 7; i += 5) begin
            div = i;
            wr(OFF_CFG, 8'(i << CFG_DIV_LSB));
            convert(2'h0, 1'b0, 1'b1);
        end
        div = 0;
        wr(OFF_CFG, 8'h00);
        convert(2'h0, 1'b1, 1'b0);
        convert(2'h2, 1'b1, 1'b1);
        repeat (1000) @(posedge clk_in);
        wr(OFF_CTRL, 8'h10);
        rdc(OFF_CTRL, 8'h00, "disabled start");
        chk("enable off", 16'h0, {15'h0, analog_out.enable});
        conclude();
    end

    initial begin
        repeat (100000) @(posedge clk_in);
        errors++;
        conclude();
    end
endmodule

`default_nettype wire
